// >>> src/mrf_pkg.sv
// Constants shared by the two-read, one-write register file.
package mrf_pkg;
    localparam int unsigned WORDS      = 8;
    localparam int unsigned WIDTH      = 2;
    localparam int unsigned ADDR_W     = 3;
    localparam logic        PHASE_RST  = 1'h0;
    localparam logic [1:0]  GATE_RST   = 2'h3;
    localparam logic [1:0]  SLAVE_RST  = 2'h0;
    localparam logic [1:0]  OUT_RST    = 2'h0;
    localparam logic [1:0]  OUT_OFF    = 2'h0;
    typedef logic [WIDTH-1:0]  mrf_word_t;
    typedef logic [ADDR_W-1:0] mrf_addr_t;
endpackage

// >>> src/mrf_regfile.sv
// Eight-word by two-bit register file with one write port and two read ports.
// Operation
// - Eight two-bit words; two reads and one write in the same cycle.
// - Written word is chosen only by the three-bit write address.
// - Each bit of a word has its own write gate.
// - Write data is loaded when the device clock rises.
// - At the rising clock, a bit is written only if its gate is low.
// - While clock is low, a rising gate writes its bit.
// - While clock is high, each port follows its own read address.
// - A port reading the word just written sees the new value.
// - At the clock fall each port captures its word into a slave.
// - While clock is low, read address changes do not alter outputs.
// - Each port has its own active-low output gate.
`timescale 1ns/1ps
module mrf_regfile (
    input  wire logic             mclk_in,
    input  wire logic             sys_rst_in,
    input  wire logic             device_phase_in,
    input  wire logic [2:0]       write_word_select_in,
    input  wire logic [2:0]       first_port_read_select_in,
    input  wire logic [2:0]       second_port_read_select_in,
    input  wire logic             low_bit_write_gate_in,
    input  wire logic             high_bit_write_gate_in,
    input  wire logic             low_bit_write_value_in,
    input  wire logic             high_bit_write_value_in,
    input  wire logic             first_port_output_gate_in,
    input  wire logic             second_port_output_gate_in,
    output logic                  first_port_low_out,
    output logic                  first_port_high_out,
    output logic                  second_port_low_out,
    output logic                  second_port_high_out
);
    mrf_pkg::mrf_word_t mem_r   [mrf_pkg::WORDS];
    mrf_pkg::mrf_word_t mem_nxt [mrf_pkg::WORDS];
    logic               phase_r;
    logic               phase_nxt;
    logic [1:0]         gate_prev_r;
    logic [1:0]         gate_prev_nxt;
    logic [1:0]         slave_b_r;
    logic [1:0]         slave_b_nxt;
    logic [1:0]         slave_c_r;
    logic [1:0]         slave_c_nxt;
    logic [1:0]         out_b_r;
    logic [1:0]         out_b_nxt;
    logic [1:0]         out_c_r;
    logic [1:0]         out_c_nxt;
    logic [1:0]         gate_now;
    logic [1:0]         wr_bit;
    logic               phase_rise;
    logic               phase_low;
    logic               pass_phase;

    // Read decode shared by both ports, looking at the post-write contents.
    function automatic mrf_pkg::mrf_word_t pick_word(input mrf_pkg::mrf_addr_t sel);
        pick_word = mem_nxt[sel];
    endfunction

    assign gate_now   = {high_bit_write_gate_in, low_bit_write_gate_in};
    assign phase_rise = device_phase_in & ~phase_r;
    assign phase_low  = ~device_phase_in & ~phase_r;
    // The cycle of the falling edge still passes, so the slave captures the word addressed in that cycle.
    assign pass_phase = device_phase_in | phase_r;

    always_comb begin
        for (int b = 0; b < mrf_pkg::WIDTH; b++) begin
            wr_bit[b] = (phase_rise & ~gate_now[b])
                      | (phase_low & gate_now[b] & ~gate_prev_r[b]);
        end
        for (int w = 0; w < mrf_pkg::WORDS; w++) begin
            mem_nxt[w] = mem_r[w];
        end
        // Only the write address steers the store.
        if (wr_bit[0]) begin
            mem_nxt[write_word_select_in][0] = low_bit_write_value_in;
        end
        if (wr_bit[1]) begin
            mem_nxt[write_word_select_in][1] = high_bit_write_value_in;
        end
    end

    always_comb begin
        phase_nxt     = device_phase_in;
        gate_prev_nxt = gate_now;
        slave_b_nxt   = slave_b_r;
        slave_c_nxt   = slave_c_r;
        if (pass_phase) begin
            slave_b_nxt = pick_word(first_port_read_select_in);
            slave_c_nxt = pick_word(second_port_read_select_in);
        end
        // Holding the slave while low keeps address changes off the outputs.
        out_b_nxt = first_port_output_gate_in ? mrf_pkg::OUT_OFF : slave_b_nxt;
        out_c_nxt = second_port_output_gate_in ? mrf_pkg::OUT_OFF : slave_c_nxt;
    end

    // Storage carries no reset so it maps onto plain latches or RAM.
    always_ff @(posedge mclk_in) begin
        for (int w = 0; w < mrf_pkg::WORDS; w++) begin
            mem_r[w] <= mem_nxt[w];
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            phase_r     <= mrf_pkg::PHASE_RST;
            gate_prev_r <= mrf_pkg::GATE_RST;
            slave_b_r   <= mrf_pkg::SLAVE_RST;
            slave_c_r   <= mrf_pkg::SLAVE_RST;
            out_b_r     <= mrf_pkg::OUT_RST;
            out_c_r     <= mrf_pkg::OUT_RST;
        end else begin
            phase_r     <= phase_nxt;
            gate_prev_r <= gate_prev_nxt;
            slave_b_r   <= slave_b_nxt;
            slave_c_r   <= slave_c_nxt;
            out_b_r     <= out_b_nxt;
            out_c_r     <= out_c_nxt;
        end
    end

    assign first_port_low_out   = out_b_r[0];
    assign first_port_high_out  = out_b_r[1];
    assign second_port_low_out  = out_c_r[0];
    assign second_port_high_out = out_c_r[1];

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);

    a_rise_write_low: assert property (phase_rise && !low_bit_write_gate_in |=>
        mem_r[$past(write_word_select_in)][0] == $past(low_bit_write_value_in))
        else $error("Low bit not written at clock rise.");
    a_rise_write_high: assert property (phase_rise && !high_bit_write_gate_in |=>
        mem_r[$past(write_word_select_in)][1] == $past(high_bit_write_value_in))
        else $error("High bit not written at clock rise.");
    // Case equality, because words that were never written hold unknowns by design.
    a_inhibit_bit: assert property (!wr_bit[0] && !wr_bit[1] |=>
        mem_r[$past(write_word_select_in)] === $past(mem_r[write_word_select_in]))
        else $error("Word changed without a write.");
    a_strobe_write: assert property (phase_low && low_bit_write_gate_in && !gate_prev_r[0] |=>
        mem_r[$past(write_word_select_in)][0] == $past(low_bit_write_value_in))
        else $error("Gate strobe did not write.");
    a_other_word: assert property (wr_bit != 2'h0 |=>
        mem_r[3'($past(write_word_select_in) + 3'h1)]
            === $past(mem_r[3'(write_word_select_in + 3'h1)]))
        else $error("Unaddressed word was written.");
    a_follow_b: assert property (device_phase_in && !first_port_output_gate_in |=>
        out_b_r === mem_r[$past(first_port_read_select_in)])
        else $error("First port not following its address.");
    a_follow_c: assert property (device_phase_in && !second_port_output_gate_in |=>
        out_c_r === mem_r[$past(second_port_read_select_in)])
        else $error("Second port not following its address.");
    a_hold_low: assert property (!device_phase_in && !phase_r && !first_port_output_gate_in
        && $past(!first_port_output_gate_in) |=> out_b_r === $past(out_b_r))
        else $error("First port changed while clock low.");
    a_off_zero: assert property (first_port_output_gate_in || second_port_output_gate_in |=>
        ($past(first_port_output_gate_in) -> out_b_r == 2'h0)
        && ($past(second_port_output_gate_in) -> out_c_r == 2'h0))
        else $error("Disabled port not low.");
    a_slave_fall: assert property (!device_phase_in && phase_r |=>
        slave_b_r === mem_r[$past(first_port_read_select_in)])
        else $error("Slave did not capture at fall.");

    c_rise_write: cover property (phase_rise && wr_bit == 2'h3);
    c_strobe: cover property (phase_low && wr_bit[1]);
    c_dual_read: cover property (device_phase_in && !first_port_output_gate_in
        && !second_port_output_gate_in
        && first_port_read_select_in != second_port_read_select_in);
    c_hold: cover property (!device_phase_in && !phase_r && $changed(first_port_read_select_in));
endmodule

// >>> verif/mrf_phase_model.sv
// Controller model that drives the register-file clock phase and the per-bit write gates.
`timescale 1ns/1ps
module mrf_phase_model (
    input  wire logic       mclk_in,
    input  wire logic       phase_req_in,
    input  wire logic [1:0] gate_req_in,
    output logic            phase_out = 1'b0,
    output logic            low_gate_out = 1'b1,
    output logic            high_gate_out = 1'b1
);
    // One register stage for all three, so a gate never slips against the phase.
    always_ff @(posedge mclk_in) begin
        phase_out     <= phase_req_in;
        low_gate_out  <= gate_req_in[0];
        high_gate_out <= gate_req_in[1];
    end
endmodule

// >>> verif/test_mrf_regfile.sv
// Self-checking bench for the two-read, one-write register file.
`timescale 1ns/1ps
module test_mrf_regfile;
    logic       mclk_in = 1'b0;
    logic       sys_rst_in = 1'b1;
    logic       ph = 1'b0;
    logic [1:0] g = 2'h3;
    logic [2:0] wa = 3'h0, ra = 3'h0, rb = 3'h0;
    logic [1:0] d = 2'h0, en = 2'h0;
    logic       phase_w, lo_g, hi_g, b0, b1, c0, c1;
    logic [1:0] mem_e [8];
    int         err_total = 0, samples_checked = 0, cycles = 0;
    always #5 mclk_in = ~mclk_in;
    mrf_phase_model pm (.mclk_in(mclk_in), .phase_req_in(ph), .gate_req_in(g),
        .phase_out(phase_w), .low_gate_out(lo_g), .high_gate_out(hi_g));
    mrf_regfile dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .device_phase_in(phase_w),
        .write_word_select_in(wa), .first_port_read_select_in(ra),
        .second_port_read_select_in(rb), .low_bit_write_gate_in(lo_g),
        .high_bit_write_gate_in(hi_g), .low_bit_write_value_in(d[0]),
        .high_bit_write_value_in(d[1]), .first_port_output_gate_in(en[0]),
        .second_port_output_gate_in(en[1]), .first_port_low_out(b0),
        .first_port_high_out(b1), .second_port_low_out(c0), .second_port_high_out(c1));
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(string what, logic [1:0] got, logic [1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge mclk_in);
    endtask
    // A write rides on the phase rise; port one watches the same word to see it land.
    task automatic wr(logic [2:0] a, logic [1:0] v, logic [1:0] gates);
        wa <= a;
        ra <= a;
        en <= 2'h0;
        d <= v;
        g <= gates;
        ph <= 1'b0;
        tick(3);
        ph <= 1'b1;
        tick(2);
        g <= 2'h3;
        mem_e[a] = (mem_e[a] & gates) | (v & ~gates);
        tick(1);
        #1;
        chk("written word", {b1, b0}, mem_e[a]);
        @(posedge mclk_in);
    endtask
    task automatic rd(logic [2:0] a, logic [2:0] b);
        ra <= a;
        rb <= b;
        en <= 2'h0;
        tick(2);
        #1;
        chk("first port", {b1, b0}, mem_e[a]);
        chk("second port", {c1, c0}, mem_e[b]);
        @(posedge mclk_in);
    endtask
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 2000) begin
            err_total++;
            print_verdict();
        end
    end
    initial begin
        tick(20);
        sys_rst_in <= 1'b0;
        for (int i = 0; i < 8; i++) wr(3'(i), i[2] ? ~2'(i) : 2'(i), 2'h0);
        for (int i = 0; i < 8; i++) rd(3'(i), 3'(7 - i));
        wr(3'h5, 2'h1, 2'h2);
        wr(3'h3, 2'h0, 2'h1);
        // Strobe write: the low gate rises while the phase is low.
        wa <= 3'h6;
        d <= 2'h0;
        g <= 2'h2;
        ph <= 1'b0;
        tick(3);
        g <= 2'h3;
        tick(3);
        mem_e[6][0] = 1'b0;
        ph <= 1'b1;
        tick(2);
        rd(3'h6, 3'h5);
        rd(3'h2, 3'h4);
        ph <= 1'b0;
        tick(3);
        ra <= 3'h4;
        rb <= 3'h2;
        tick(3);
        #1;
        chk("held first", {b1, b0}, mem_e[2]);
        chk("held second", {c1, c0}, mem_e[4]);
        @(posedge mclk_in);
        en <= 2'h1;
        tick(2);
        #1;
        chk("gated first", {b1, b0}, 2'h0);
        chk("open second", {c1, c0}, mem_e[4]);
        print_verdict();
    end
endmodule
